// [dv/core_model.sv]
// processor core stand-in: advances the program address while running
// assumes the controller halts it during sleep and signals vector_take
module core_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic core_halt,
  input wire logic vector_take,
  input wire logic [12:0] vector_addr,
  output logic [12:0] pc
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) begin
    if (reset) begin
      pc <= 13'h0000;
    end else if (vector_take) begin
      pc <= vector_addr;
    end else if (!core_halt) begin
      pc <= pc + 13'h0001;
    end
  end
endmodule

// [dv/sleep_wakeup_controller_tb.sv]
// self-checking bench for the sleep/wake controller
// assumes core_model supplies the program address
`include "sleep_wake_params.svh"
module sleep_wakeup_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, external_reset_pin_n = 1, sleep_instr = 0;
  logic watchdog_clear_instr = 0, watchdog_enabled = 0, watchdog_timeout = 0;
  logic global_irq_enable = 0, timer_one_async = 0, adc_on_internal_rc = 0;
  logic [8:0] irq_flag = 9'h000, irq_enable = 9'h000;
  logic [2:0] osc_mode = 3'h0;
  logic [12:0] pc, prefetch_addr, vector_addr;
  logic wake_request, core_halt, device_reset, osc_driver_on, watchdog_clear;
  logic powerdown_flag, timeout_flag, prefetch_en, resume, vector_take;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n;
  always #20 clk = ~clk;
  sleep_wakeup_controller dut (.clk(clk), .reset(reset),
    .external_reset_pin_n(external_reset_pin_n), .sleep_instr(sleep_instr),
    .watchdog_clear_instr(watchdog_clear_instr), .watchdog_enabled(watchdog_enabled),
    .watchdog_timeout(watchdog_timeout), .global_irq_enable(global_irq_enable),
    .irq_flag(irq_flag), .irq_enable(irq_enable), .timer_one_async(timer_one_async),
    .adc_on_internal_rc(adc_on_internal_rc), .osc_mode(osc_mode), .pc(pc),
    .wake_request(wake_request), .core_halt(core_halt), .device_reset(device_reset),
    .osc_driver_on(osc_driver_on), .watchdog_clear(watchdog_clear),
    .powerdown_flag(powerdown_flag), .timeout_flag(timeout_flag),
    .prefetch_en(prefetch_en), .prefetch_addr(prefetch_addr), .resume(resume),
    .vector_take(vector_take), .vector_addr(vector_addr));
  core_model core (.clk(clk), .reset(reset), .core_halt(core_halt),
    .vector_take(vector_take), .vector_addr(vector_addr), .pc(pc));
  task end_of_test();
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // one sleep instruction; nop set when an enabled irq is pending
  task sleep_go(input logic nop);
    logic [12:0] exp;
    @(posedge clk) sleep_instr <= 1'b1;
    #1 exp = pc + 13'h0001;
    @(posedge clk) sleep_instr <= 1'b0;
    #1 chk((prefetch_en & watchdog_clear) === !nop, "exec");
    @(posedge clk);
    #1;
    if (nop) chk(core_halt === 1'b0 && powerdown_flag === 1'b1, "nop");
    else chk(core_halt === 1'b1 && powerdown_flag === 1'b0 && timeout_flag === 1'b1 &&
      osc_driver_on === 1'b0 && prefetch_addr === exp, "asleep");
  endtask
  task wait_resume(input int lim, output int cnt);
    cnt = 0;
    #1;
    while (resume !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      #1 cnt++;
      if (cnt == 500) chk(watchdog_clear === 1'b1, "ost hold");
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk(powerdown_flag === 1'b1 && timeout_flag === 1'b1 && core_halt === 1'b0 &&
      osc_driver_on === 1'b1 && vector_addr === 13'h0004, "reset");
    for (int i = 0; i < 9; i++) begin
      @(posedge clk) begin
        irq_flag <= 9'h001 << i;
        irq_enable <= 9'h000;
        timer_one_async <= 1'b0;
        adc_on_internal_rc <= 1'b0;
      end
      #1 chk(wake_request === 1'b0, "no enable");
      @(posedge clk) irq_enable <= 9'h001 << i;
      #1 chk(wake_request === (i != 0 && i != 2), "qualifier");
      @(posedge clk) begin
        timer_one_async <= 1'b1;
        adc_on_internal_rc <= 1'b1;
      end
      #1 chk(wake_request === 1'b1, "source");
    end
    sleep_go(1'b1);
    @(posedge clk) begin
      irq_flag <= 9'h000;
      irq_enable <= 9'h010;
    end
    sleep_go(1'b0);
    @(posedge clk) begin
      irq_flag <= 9'h020;
      osc_mode <= `OSC_RESISTOR_CAP;
    end
    wait_resume(20, n);
    chk(n == 20 && core_halt === 1'b1, "stray wake");
    @(posedge clk) irq_flag <= 9'h010;
    wait_resume(8, n);
    chk(n >= 1 && n <= 3 && vector_take === 1'b0, "late irq wake");
    for (int m = 0; m < 5; m++) begin
      @(posedge clk) begin
        irq_flag <= 9'h000;
        osc_mode <= 3'(m);
        global_irq_enable <= (m < 3);
      end
      sleep_go(1'b0);
      @(posedge clk) irq_flag <= 9'h010;
      wait_resume(1100, n);
      chk((m < 3 ? (n >= 1024 && n <= 1027) : (n >= 1 && n <= 3)) &&
        vector_take === (m < 3), "wake timing");
      @(posedge clk);
      #1 chk(powerdown_flag === 1'b0 && timeout_flag === 1'b1 && device_reset === 1'b0 &&
        core_halt === 1'b0, "after wake");
    end
    @(posedge clk) begin
      irq_flag <= 9'h000;
      watchdog_enabled <= 1'b1;
      osc_mode <= `OSC_EXTERNAL_CLOCK;
    end
    sleep_go(1'b0);
    @(posedge clk) watchdog_timeout <= 1'b1;
    @(posedge clk) watchdog_timeout <= 1'b0;
    wait_resume(8, n);
    @(posedge clk);
    #1 chk(n <= 3 && timeout_flag === 1'b0 && device_reset === 1'b0, "wdt wake");
    @(posedge clk) watchdog_clear_instr <= 1'b1;
    #1 chk(watchdog_clear === 1'b1, "clear instr");
    @(posedge clk) watchdog_clear_instr <= 1'b0;
    @(posedge clk);
    #1 chk(powerdown_flag === 1'b1 && timeout_flag === 1'b1, "flags set");
    sleep_go(1'b0);
    @(posedge clk) external_reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(device_reset === 1'b1 && core_halt === 1'b0 && wake_request === 1'b1, "pin");
    @(posedge clk) external_reset_pin_n <= 1'b1;
    end_of_test();
  end
endmodule

// [hdl/osc_startup_counter.sv]
// oscillator start-up counter, counts oscillator periods after wake
// assumes one oscillator period per clk cycle
`include "sleep_wake_params.svh"
module osc_startup_counter (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  output logic done
);
  logic [10:0] count_reg;
  logic running_reg;
  always_ff @(posedge clk) begin
    if (reset || start) begin
      count_reg <= 11'h000;
    end else if (running_reg) begin
      count_reg <= count_reg + 11'h001;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      running_reg <= 1'b0;
    end else if (start) begin
      running_reg <= 1'b1;
    end else if (count_reg == 11'(`OST_PERIODS - 1)) begin
      running_reg <= 1'b0;
    end
  end
  assign done = running_reg && (count_reg == 11'(`OST_PERIODS - 1));
endmodule

// [hdl/sleep_wake_params.svh]
// timing constants and fixed values for the sleep/wake controller
// assumes inclusion by bare name from the package and design modules
`ifndef SLEEP_WAKE_PARAMS_SVH
`define SLEEP_WAKE_PARAMS_SVH
`define OST_PERIODS 1024
`define IRQ_VECTOR_ADDR 13'h0004
`define PC_WIDTH 13
`define NUM_WAKE_SRC 9
`define SRC_TIMER_ONE 0
`define SRC_CAPTURE 1
`define SRC_ADC 2
`define SRC_EEPROM 3
`define SRC_COMPARATOR 4
`define SRC_PORT_CHANGE 5
`define SRC_EDGE_IRQ 6
`define SRC_SERIAL_BREAK 7
`define SRC_TWO_WIRE 8
`define OSC_CRYSTAL_SLOW 3'h0
`define OSC_CRYSTAL_MEDIUM 3'h1
`define OSC_CRYSTAL_FAST 3'h2
`define OSC_EXTERNAL_CLOCK 3'h3
`define OSC_RESISTOR_CAP 3'h4
`endif

// [hdl/sleep_wake_pkg.sv]
// types for the sleep/wake controller
// assumes sleep_wake_params.svh is on the include path
`include "sleep_wake_params.svh"
package sleep_wake_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP_EXEC,
    ST_ASLEEP,
    ST_OST_WAIT,
    ST_RESUME
  } sleep_state_t;
  typedef logic [`NUM_WAKE_SRC-1:0] src_vec_t;
endpackage

// [hdl/sleep_wakeup_controller.sv]
// sleep entry and wake-up sequencing for the core
// assumes core pulses sleep_instr for one cycle and waits for resume
// Operation
// - wake on reset pin, watchdog time-out when enabled, or enabled interrupt
// - reset pin wake gives full reset; other wakes resume execution
// - power-down flag set at power-up, cleared on sleep entry
// - time-out flag cleared when watchdog time-out caused the wake
// - listed peripheral interrupts, with mode qualifiers, may wake the device
// - clocked peripherals cannot interrupt while asleep
// - next instruction prefetched while sleep executes
// - source wakes only with its own enable set, regardless of global enable
// - after interrupt wake run next instruction, then vector 0004h if enabled; code vectors in the resume cycle, before any instruction runs
// - pending enabled flag at the sleep instruction: sleep not entered, core keeps running; code sleeps on a timer one or ADC flag lacking its qualifier
// - watchdog cleared on interrupt and watchdog wakes; reset pin wake returns straight to run
// - interrupt pending before sleep makes sleep a no-operation; code sleeps on a timer one or ADC flag lacking its qualifier
// - interrupt during or after sleep: sleep completes, then wakes
// - crystal modes wait 1024 oscillator periods before resuming
// - sleep entry clears watchdog, clears power-down, sets time-out, osc off
// - watchdog held cleared until start-up delay expires
`include "sleep_wake_params.svh"
module sleep_wakeup_controller (
  input wire logic clk,
  input wire logic reset,
  input wire logic external_reset_pin_n,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic watchdog_enabled,
  input wire logic watchdog_timeout,
  input wire logic global_irq_enable,
  input wire logic [`NUM_WAKE_SRC-1:0] irq_flag,
  input wire logic [`NUM_WAKE_SRC-1:0] irq_enable,
  input wire logic timer_one_async,
  input wire logic adc_on_internal_rc,
  input wire logic [2:0] osc_mode,
  input wire logic [`PC_WIDTH-1:0] pc,
  output logic wake_request,
  output logic core_halt,
  output logic device_reset,
  output logic osc_driver_on,
  output logic watchdog_clear,
  output logic powerdown_flag,
  output logic timeout_flag,
  output logic prefetch_en,
  output logic [`PC_WIDTH-1:0] prefetch_addr,
  output logic resume,
  output logic vector_take,
  output logic [`PC_WIDTH-1:0] vector_addr
);
  sleep_wake_pkg::sleep_state_t state_reg;
  sleep_wake_pkg::src_vec_t src_qual;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic irq_wake;
  logic ost_start;
  logic ost_done;
  logic vector_pending_reg;
  logic crystal;

  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == `OSC_CRYSTAL_SLOW) || (mode == `OSC_CRYSTAL_MEDIUM) ||
      (mode == `OSC_CRYSTAL_FAST);
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= ~external_reset_pin_n;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // per-source qualification of wake capability
  genvar i;
  generate
    for (i = 0; i < `NUM_WAKE_SRC; i++) begin : g_src
      if (i == `SRC_TIMER_ONE) begin : g_t1
        assign src_qual[i] = irq_enable[i] & irq_flag[i] & timer_one_async;
      end else if (i == `SRC_ADC) begin : g_adc
        assign src_qual[i] = irq_enable[i] & irq_flag[i] & adc_on_internal_rc;
      end else begin : g_other
        assign src_qual[i] = irq_enable[i] & irq_flag[i];
      end
    end
  endgenerate

  assign irq_wake = |src_qual;
  // unclocked wake request, usable while clocks are stopped
  assign wake_request = irq_wake | ~external_reset_pin_n |
    (watchdog_enabled & watchdog_timeout);
  assign crystal = is_crystal(osc_mode);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= sleep_wake_pkg::ST_RUN;
    end else begin
      case (state_reg)
        sleep_wake_pkg::ST_RUN: begin
          if (sleep_instr && !irq_wake) begin
            state_reg <= sleep_wake_pkg::ST_SLEEP_EXEC;
          end
        end
        sleep_wake_pkg::ST_SLEEP_EXEC: begin
          state_reg <= sleep_wake_pkg::ST_ASLEEP;
        end
        sleep_wake_pkg::ST_ASLEEP: begin
          if (pin_sync_reg) begin
            state_reg <= sleep_wake_pkg::ST_RUN;
          end else if (irq_wake || (watchdog_enabled && watchdog_timeout)) begin
            state_reg <= crystal ? sleep_wake_pkg::ST_OST_WAIT
              : sleep_wake_pkg::ST_RESUME;
          end
        end
        sleep_wake_pkg::ST_OST_WAIT: begin
          if (ost_done) begin
            state_reg <= sleep_wake_pkg::ST_RESUME;
          end
        end
        sleep_wake_pkg::ST_RESUME: begin
          state_reg <= sleep_wake_pkg::ST_RUN;
        end
        default: begin
          state_reg <= sleep_wake_pkg::ST_RUN;
        end
      endcase
    end
  end

  assign ost_start = (state_reg == sleep_wake_pkg::ST_ASLEEP) && !pin_sync_reg &&
    (irq_wake || (watchdog_enabled && watchdog_timeout)) && crystal;

  osc_startup_counter u_ost (
    .clk(clk),
    .reset(reset),
    .start(ost_start),
    .done(ost_done)
  );

  // cycles spent so far in the start-up wait, watched by the checks only
  logic [10:0] ost_wait_cnt_reg;
  always_ff @(posedge clk) begin
    if (reset || state_reg != sleep_wake_pkg::ST_OST_WAIT) begin
      ost_wait_cnt_reg <= 11'h000;
    end else begin
      ost_wait_cnt_reg <= ost_wait_cnt_reg + 11'h001;
    end
  end

  // status flags; power-up sets both
  always_ff @(posedge clk) begin
    if (reset) begin
      powerdown_flag <= 1'b1;
    end else if (watchdog_clear_instr) begin
      powerdown_flag <= 1'b1;
    end else if (state_reg == sleep_wake_pkg::ST_SLEEP_EXEC) begin
      powerdown_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timeout_flag <= 1'b1;
    end else if (watchdog_clear_instr || state_reg == sleep_wake_pkg::ST_SLEEP_EXEC) begin
      timeout_flag <= 1'b1;
    end else if (state_reg == sleep_wake_pkg::ST_ASLEEP && !irq_wake && !pin_sync_reg &&
        watchdog_enabled && watchdog_timeout) begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      vector_pending_reg <= 1'b0;
    end else if (state_reg == sleep_wake_pkg::ST_ASLEEP) begin
      vector_pending_reg <= irq_wake && global_irq_enable;
    end else if (state_reg == sleep_wake_pkg::ST_RUN) begin
      vector_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prefetch_addr <= '0;
    end else if (sleep_instr) begin
      prefetch_addr <= pc + `PC_WIDTH'(1);
    end
  end

  assign prefetch_en = (state_reg == sleep_wake_pkg::ST_SLEEP_EXEC);
  assign core_halt = (state_reg != sleep_wake_pkg::ST_RUN) &&
    (state_reg != sleep_wake_pkg::ST_SLEEP_EXEC);
  assign device_reset = pin_sync_reg;
  assign osc_driver_on = (state_reg != sleep_wake_pkg::ST_ASLEEP);
  assign watchdog_clear = watchdog_clear_instr ||
    (state_reg == sleep_wake_pkg::ST_SLEEP_EXEC) ||
    (state_reg == sleep_wake_pkg::ST_OST_WAIT) ||
    (state_reg == sleep_wake_pkg::ST_RESUME);
  assign resume = (state_reg == sleep_wake_pkg::ST_RESUME);
  assign vector_take = resume && vector_pending_reg;
  assign vector_addr = `IRQ_VECTOR_ADDR;

  // named sequences for the sleep flow
  sequence sleep_taken_s;
    state_reg == sleep_wake_pkg::ST_RUN && sleep_instr && !irq_wake;
  endsequence
  sequence sleep_done_s;
    ##1 (state_reg == sleep_wake_pkg::ST_SLEEP_EXEC) ##1 !powerdown_flag && timeout_flag;
  endsequence

  sleep_entry_flags_a: assert property (@(posedge clk) disable iff (reset)
    sleep_taken_s |-> sleep_done_s) else $error("sleep entry flags wrong");
  sleep_nop_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == sleep_wake_pkg::ST_RUN && sleep_instr && irq_wake && !watchdog_clear_instr)
    |=> ($stable(powerdown_flag) && state_reg == sleep_wake_pkg::ST_RUN))
    else $error("sleep not a nop with pending irq");
  ost_delay_a: assert property (@(posedge clk) disable iff (reset)
    ost_start |=> (state_reg == sleep_wake_pkg::ST_OST_WAIT) [*8])
    else $error("start-up delay wrong");
  ost_exit_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == sleep_wake_pkg::ST_OST_WAIT) |=>
    (resume == (ost_wait_cnt_reg == 11'(`OST_PERIODS))))
    else $error("start-up exit wrong");
  no_ost_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == sleep_wake_pkg::ST_ASLEEP && !crystal && irq_wake && !pin_sync_reg)
    |=> resume) else $error("non-crystal resume delayed");
  wdt_hold_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == sleep_wake_pkg::ST_OST_WAIT) |-> watchdog_clear ##1 watchdog_clear)
    else $error("watchdog not held in start-up");
  pin_reset_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == sleep_wake_pkg::ST_ASLEEP && pin_sync_reg)
    |=> (state_reg == sleep_wake_pkg::ST_RUN && !resume)) else $error("pin wake not reset");
  vector_branch_a: assert property (@(posedge clk) disable iff (reset)
    vector_take |-> (vector_addr == 13'h0004 && $past(state_reg) != sleep_wake_pkg::ST_RUN))
    else $error("bad vector");
  wdt_wake_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == sleep_wake_pkg::ST_ASLEEP && !irq_wake && !pin_sync_reg && watchdog_enabled
    && watchdog_timeout && !watchdog_clear_instr) |=> !timeout_flag)
    else $error("time-out flag not cleared");
  osc_off_a: assert property (@(posedge clk) disable iff (reset)
    sleep_taken_s |-> ##2 !osc_driver_on) else $error("osc on asleep");
endmodule
